// >>> rtl/adcsf_pkg.sv
// package for the converter status-flag block
// assumes a single clock domain and no register bus
package adcsf_pkg;
    localparam int ADCSF_CHANNELS = 4;
    localparam int ADCSF_DATA_W = 10;
    localparam int ADCSF_CH_W = 2;
    localparam logic ADCSF_FLAG_RESET = 1'b0;
    localparam logic [9:0] ADCSF_DATA_RESET = 10'h000;
endpackage

// >>> rtl/adcsf_eoc_if.sv
// interface carrying one end-of-conversion event to the flag module
// assumes the event is a one-cycle pulse on mclk
`timescale 1ns/1ps
`default_nettype none
interface adcsf_eoc_if #(parameter int CH = 4, parameter int CW = 2, parameter int DW = 10);
    logic valid;
    logic [CW-1:0] chan;
    logic [DW-1:0] data;
    logic [CH-1:0] enabled;
    modport src (output valid, output chan, output data, output enabled);
    modport dst (input valid, input chan, input data, input enabled);
endinterface
`default_nettype wire

// >>> rtl/adcsf_chan_flags.sv
// per-channel done and overrun flags for one channel
// assumes read strobes are one-cycle pulses from the same clock
`timescale 1ns/1ps
`default_nettype none
module adcsf_chan_flags
    import adcsf_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic store,
    input wire logic clr_done,
    input wire logic clr_ovr,
    output logic done,
    output logic ovr
);
    always_ff @(posedge mclk) begin
        if (rst) begin
            done <= ADCSF_FLAG_RESET;
        end else if (store) begin
            done <= 1'b1;
        end else if (clr_done) begin
            done <= 1'b0; // [RULE9]
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ovr <= ADCSF_FLAG_RESET;
        end else if (store && done && !clr_done) begin
            ovr <= 1'b1; // [RULE11]
        end else if (clr_ovr) begin
            ovr <= 1'b0; // [RULE10]
        end
    end
endmodule
`default_nettype wire

// >>> rtl/adcsf_top.sv
// converter result registers and status flags
// assumes eoc, reads and enables come from logic on mclk
// Functional notes
// [RULE1] only last-result read clears ready flag
// [RULE2] disabled-channel completion never sets ready flag
// [RULE3] channel read does not block ready set
// [RULE4] disable elsewhere still stores and sets ready
// [RULE5] status read with completion: set beats clear
// [RULE6] completion while ready active and no last-result read sets any-overrun
// [RULE7] channel read does not block any-overrun set
// [RULE8] disable elsewhere still sets both overrun flags
// [RULE9] channel or last read clears done flag
// [RULE10] status read clears channel overrun despite done
// [RULE11] completion over unread done sets channel overrun
`timescale 1ns/1ps
`default_nettype none
module adcsf_top
    import adcsf_pkg::*;
#(
    parameter int CHANNELS = ADCSF_CHANNELS,
    parameter int DATA_W = ADCSF_DATA_W
)(
    input wire logic mclk,
    input wire logic rst,
    input wire logic eoc_valid,
    input wire logic [ADCSF_CH_W-1:0] eoc_chan,
    input wire logic [DATA_W-1:0] eoc_data,
    input wire logic [CHANNELS-1:0] chan_enable,
    input wire logic rd_last,
    input wire logic rd_chan,
    input wire logic [ADCSF_CH_W-1:0] rd_chan_sel,
    input wire logic rd_status,
    output logic [DATA_W-1:0] last_result_reg,
    output logic [ADCSF_CH_W-1:0] last_result_chan,
    output logic [CHANNELS*DATA_W-1:0] channel_result_reg,
    output logic [CHANNELS-1:0] done_flags,
    output logic [CHANNELS-1:0] channel_overrun_flag,
    output logic result_ready_flag,
    output logic any_overrun_flag
);
    if (CHANNELS != (1 << ADCSF_CH_W)) begin : g_bad_channels
        $error("adcsf_top: channel count must match the select width");
    end
    if (DATA_W != ADCSF_DATA_W) begin : g_bad_width
        $error("adcsf_top: data width must match the reset value width");
    end

    adcsf_eoc_if #(.CH(CHANNELS), .CW(ADCSF_CH_W), .DW(DATA_W)) eoc ();
    assign eoc.valid = eoc_valid;
    assign eoc.chan = eoc_chan;
    assign eoc.data = eoc_data;
    assign eoc.enabled = chan_enable;

    // per-channel events of this cycle
    logic store_any;
    logic [CHANNELS-1:0] store_hit;
    logic [CHANNELS-1:0] chan_rd_hit;
    logic [CHANNELS-1:0] last_rd_hit;
    logic [CHANNELS-1:0] done_q;
    logic [CHANNELS-1:0] ovr_q;

    // a completion stores only for an enabled channel
    assign store_any = eoc.valid && eoc.enabled[eoc.chan]; // [RULE2] [RULE4]

    genvar i;
    generate
        for (i = 0; i < CHANNELS; i++) begin : g_ch
            assign store_hit[i] = store_any && (eoc.chan == ADCSF_CH_W'(i));
            assign chan_rd_hit[i] = rd_chan && (rd_chan_sel == ADCSF_CH_W'(i));
            assign last_rd_hit[i] = rd_last && (last_result_chan == ADCSF_CH_W'(i));
            adcsf_chan_flags u_flags (
                .mclk(mclk),
                .rst(rst),
                .store(store_hit[i]),
                .clr_done(chan_rd_hit[i] || last_rd_hit[i]), // [RULE9]
                .clr_ovr(rd_status), // [RULE10]
                .done(done_q[i]),
                .ovr(ovr_q[i])
            );
        end
    endgenerate

    // one result slot per channel, written only by its own completion
    always_ff @(posedge mclk) begin
        if (rst) begin
            channel_result_reg <= {CHANNELS{ADCSF_DATA_RESET}};
        end else begin
            for (int k = 0; k < CHANNELS; k++) begin
                if (store_hit[k]) begin
                    channel_result_reg[k*DATA_W +: DATA_W] <= eoc.data; // [RULE4]
                end
            end
        end
    end

    // flag outputs follow the per-channel flags one cycle later
    always_ff @(posedge mclk) begin
        if (rst) begin
            done_flags <= '0;
        end else begin
            done_flags <= done_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            channel_overrun_flag <= '0;
        end else begin
            channel_overrun_flag <= ovr_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            last_result_reg <= ADCSF_DATA_RESET;
        end else if (store_any) begin
            last_result_reg <= eoc.data; // [RULE4]
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            last_result_chan <= '0;
        end else if (store_any) begin
            last_result_chan <= eoc.chan;
        end
    end

    // global events; a coinciding last-result read consumes the pending result
    logic ready_set;
    logic ready_clr;
    logic any_ovr_set;
    logic any_ovr_clr;
    assign ready_set = store_any; // [RULE3] [RULE4]
    assign ready_clr = rd_last; // [RULE1] [RULE2]
    assign any_ovr_set = store_any && result_ready_flag && !rd_last; // [RULE6] [RULE7] [RULE8]
    assign any_ovr_clr = rd_status; // [RULE5]

    // ready: set by a stored result, cleared only by last-result read
    always_ff @(posedge mclk) begin
        if (rst) begin
            result_ready_flag <= ADCSF_FLAG_RESET;
        end else if (ready_set) begin
            result_ready_flag <= 1'b1; // [RULE3] [RULE4]
        end else if (ready_clr) begin
            result_ready_flag <= 1'b0; // [RULE1] [RULE2]
        end
    end

    // any-overrun: completion over pending ready; set wins over status read
    always_ff @(posedge mclk) begin
        if (rst) begin
            any_overrun_flag <= ADCSF_FLAG_RESET;
        end else if (any_ovr_set) begin
            any_overrun_flag <= 1'b1; // [RULE6] [RULE7] [RULE8] [RULE5]
        end else if (any_ovr_clr) begin
            any_overrun_flag <= 1'b0; // [RULE5]
        end
    end
endmodule
`default_nettype wire

// >>> sim/adcsf_chk.sv
// assertions on the status-flag ports
// assumes bind to adcsf_top, one clock mclk
`timescale 1ns/1ps
`default_nettype none
module adcsf_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic eoc_valid,
    input wire logic [1:0] eoc_chan,
    input wire logic [3:0] chan_enable,
    input wire logic rd_last,
    input wire logic rd_chan,
    input wire logic [1:0] rd_chan_sel,
    input wire logic rd_status,
    input wire logic [3:0] done_flags,
    input wire logic [3:0] channel_overrun_flag,
    input wire logic result_ready_flag,
    input wire logic any_overrun_flag
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire st = eoc_valid && chan_enable[eoc_chan];
    a_store_sets_ready: assert property (st |=> result_ready_flag)
        else $error("ready not set");
    a_disabled_no_ready: assert property (eoc_valid && !st && rd_last |=> !result_ready_flag)
        else $error("ready set");
    a_chan_read_keeps: assert property (
        rd_chan && !rd_last && result_ready_flag |=> result_ready_flag)
        else $error("ready lost");
    a_last_read_clears: assert property (rd_last && !st |=> !result_ready_flag)
        else $error("ready kept");
    a_any_ovr_set: assert property (
        st && result_ready_flag && !rd_last |=> any_overrun_flag)
        else $error("no overrun");
    a_status_clears: assert property (
        rd_status && !(st && result_ready_flag && !rd_last) |=> !any_overrun_flag)
        else $error("overrun kept");
    a_done_set: assert property (st |-> ##2 done_flags[$past(eoc_chan, 2)])
        else $error("done not set");
    a_done_clear: assert property (
        rd_chan && !eoc_valid |-> ##2 !done_flags[$past(rd_chan_sel, 2)])
        else $error("done kept");
    a_chan_ovr_set: assert property (
        st && done_flags[eoc_chan] && !rd_chan && !rd_last && !$past(rd_chan) && !$past(rd_last)
        |-> ##2 channel_overrun_flag[$past(eoc_chan, 2)])
        else $error("chan overrun not set");
    a_status_ovr_clr: assert property (
        rd_status && done_flags == 4'h0 && !$past(eoc_valid) |-> ##2 channel_overrun_flag == 4'h0)
        else $error("chan overrun kept");
    a_status_ovr_eoc: assert property (
        rd_status && st && !done_flags[eoc_chan] && !$past(eoc_valid)
        |-> ##2 !channel_overrun_flag[$past(eoc_chan, 2)])
        else $error("chan overrun kept on completion");
    c_store: cover property (st && result_ready_flag);
    c_status: cover property (rd_status && st);
    c_chan: cover property (rd_chan && st);
    c_disable: cover property (st && result_ready_flag && chan_enable != $past(chan_enable));
endmodule
bind adcsf_top adcsf_chk adcsf_chk_i (
    .mclk(mclk),
    .rst(rst),
    .eoc_valid(eoc_valid),
    .eoc_chan(eoc_chan),
    .chan_enable(chan_enable),
    .rd_last(rd_last),
    .rd_chan(rd_chan),
    .rd_chan_sel(rd_chan_sel),
    .rd_status(rd_status),
    .done_flags(done_flags),
    .channel_overrun_flag(channel_overrun_flag),
    .result_ready_flag(result_ready_flag),
    .any_overrun_flag(any_overrun_flag)
);
`default_nettype wire

// >>> sim/adc_result_status_flags_test.sv
// self-checking bench for the status-flag block
// assumes adcsf_top with default parameters
`timescale 1ns/1ps
`default_nettype none
module adc_result_status_flags_test;
    logic mclk = 0, rst = 1, ev = 0, rl = 0, rc = 0, rs = 0;
    logic [1:0] ec = 0, sel = 0, lch;
    logic [9:0] ed = 0, lr;
    logic [3:0] en = 4'hf, df, of;
    logic [39:0] cr;
    logic rdy, gov;
    int errors = 0, cmp_count = 0, cyc = 0;
    always #4 mclk = ~mclk;
    adcsf_top adcsf_top_i (.mclk(mclk), .rst(rst), .eoc_valid(ev), .eoc_chan(ec), .eoc_data(ed), .chan_enable(en),
        .rd_last(rl), .rd_chan(rc), .rd_chan_sel(sel), .rd_status(rs), .last_result_reg(lr), .last_result_chan(lch),
        .channel_result_reg(cr), .done_flags(df), .channel_overrun_flag(of), .result_ready_flag(rdy),
        .any_overrun_flag(gov));
    task automatic test_done();
        if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [39:0] s, input logic [39:0] x);
        cmp_count++;
        if (s !== x) begin
            errors++;
            $display("wrong value %s exp %h seen %h", n, x, s);
        end
    endtask
    // one cycle of stimulus, held until the next step drives new values
    task automatic step(input logic v, input logic [1:0] c, input logic [3:0] e, input logic l, r, s);
        ev = v;
        ec = c;
        ed = {c, 8'h5a};
        en = e;
        rl = l;
        rc = r;
        rs = s;
        sel = c + 2'h1;
        @(posedge mclk);
        #1;
    endtask
    task automatic t_store();
        step(1, 1, 4'he, 0, 0, 0);
        chk("last", lr, {2'h1, 8'h5a});
        chk("lch", lch, 2'h1);
        chk("chan", cr[19:10], {2'h1, 8'h5a});
        chk("ready", rdy, 1);
        step(0, 0, 4'hf, 0, 1, 0);
        chk("ready", rdy, 1);
        chk("done", df, 4'h2);
        step(0, 0, 4'hf, 0, 0, 0);
        chk("done", df, 0);
        step(0, 0, 4'hf, 1, 0, 0);
        chk("ready", rdy, 0);
    endtask
    task automatic t_overrun();
        step(1, 2, 4'hf, 0, 0, 0);
        step(1, 2, 4'he, 0, 0, 0);
        chk("gov", gov, 1);
        step(0, 0, 4'he, 0, 0, 0);
        chk("ovr", of, 4'h4);
        step(0, 0, 4'he, 0, 0, 1);
        chk("gov", gov, 0);
        step(1, 0, 4'he, 1, 0, 0);
        chk("ready", rdy, 0);
        chk("last", lr, {2'h2, 8'h5a});
    endtask
    task automatic t_cross();
        step(1, 1, 4'hf, 0, 0, 0);
        chk("done", df, 4'h0);
        step(1, 1, 4'hf, 0, 1, 0);
        chk("ready", rdy, 1);
        chk("gov", gov, 1);
        step(0, 0, 4'hf, 0, 1, 0);
        step(0, 0, 4'hf, 0, 0, 0);
        chk("ovr", of, 4'h2);
        step(1, 1, 4'hf, 0, 0, 1);
        chk("gov", gov, 1);
        step(0, 0, 4'hf, 0, 0, 0);
        chk("ovr", of, 0);
        chk("done", df, 4'h2);
        step(0, 0, 4'hf, 0, 0, 1);
        chk("gov", gov, 0);
        step(1, 3, 4'hf, 0, 0, 1);
        chk("gov", gov, 1);
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 500) begin
            errors++;
            test_done();
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        #1 rst = 0;
        t_store();
        t_overrun();
        t_cross();
        test_done();
    end
endmodule
`default_nettype wire
